// >>> tb/byte_load_sva.sv
`timescale 1ns/1ps
module byte_load_sva
  import byte_load_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic              config_request_n,
  input wire logic              cfg_state_flag_n,
  input wire logic              load_complete,
  input wire logic              load_clock,
  input wire logic [BYTE_W-1:0] load_data,
  input wire logic              load_data_oe
);
  localparam int REQ_LOW_MAX = REQ_TO_LOW_CYC;
  logic [CNT_W-1:0] req_lo_ff;
  logic [CNT_W-1:0] req_hi_ff;
  logic [CNT_W-1:0] stat_lo_ff;
  logic [CNT_W-1:0] stat_hi_ff;

  // saturating, so a long user-mode stay cannot wrap into a false short span
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
    bump = (&v) ? v : v + 1'b1;
  endfunction

  // ==========================================================
  // span counters
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_lo_ff  <= '0;
      req_hi_ff  <= '0;
      stat_lo_ff <= '0;
      stat_hi_ff <= '0;
    end else begin
      req_lo_ff  <= config_request_n ? '0 : bump(req_lo_ff);
      req_hi_ff  <= config_request_n ? bump(req_hi_ff) : '0;
      stat_lo_ff <= cfg_state_flag_n ? '0 : bump(stat_lo_ff);
      stat_hi_ff <= cfg_state_flag_n ? bump(stat_hi_ff) : '0;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence req_fall_s;  $fell(config_request_n); endsequence
  sequence lines_low_s; !cfg_state_flag_n && !load_complete; endsequence
  sequence clk_still_s; $stable(load_clock) [*8]; endsequence

  a_req_lines_low: assert property (req_fall_s |-> ##[0:REQ_LOW_MAX] lines_low_s)
    else $error("status or load-complete not low after request fall");
  a_req_pulse_width: assert property ($rose(config_request_n) |-> req_lo_ff >= REQ_LOW_CYC)
    else $error("request low pulse too short");
  a_status_low_width: assert property ($rose(cfg_state_flag_n) |-> stat_lo_ff >= STATUS_LOW_CYC)
    else $error("status low pulse too short");
  a_status_rise_late: assert property ($rose(cfg_state_flag_n) |-> req_hi_ff <= 16'h2710)
    else $error("status rose too late after request rise");
  a_first_clk_wait: assert property ($rose(load_clock) |-> stat_hi_ff >= STAT_CLK_CYC && req_hi_ff >= REQ_CLK_CYC)
    else $error("load clock rose too early");
  // the request reaches the device through two flip-flops, so it takes two cycles to act
  a_reset_holds_done: assert property (
    (!config_request_n && req_lo_ff >= 16'h0002) || !cfg_state_flag_n |-> !load_complete)
    else $error("load-complete high while in reset");
  a_done_idle_high: assert property ($rose(load_complete) |-> config_request_n && cfg_state_flag_n)
    else $error("load-complete rose with a control line low");
  a_data_before_rise: assert property ($rose(load_clock) |-> load_data_oe && $stable(load_data))
    else $error("load data moved at load clock rise");
  a_clk_parked: assert property ($rose(load_complete) |-> ##24 clk_still_s)
    else $error("load clock not parked after configuration");
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import byte_load_pkg::*;
  localparam int NBYTES = 16;
  logic              sys_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              use_user_clk_i = 1'b0;
  logic              user_startup_clock_i = 1'b0;
  logic              byte_ready_i = 1'b0;
  logic              start_i = 1'b0;
  logic              src_valid_i = 1'b0;
  logic [BYTE_W-1:0] src_data_i = 8'h00;
  logic              byte_valid_o, user_mode_o, src_ready_o, busy_o, error_o, done_o;
  logic [BYTE_W-1:0] byte_data_o, user_io_o, exp_b;
  logic              uclk_run = 1'b0;
  logic              stall = 1'b0;
  logic [BYTE_W-1:0] exp_q[$];
  int                seed = 32'ha2ee_19dc;
  int                got_n, mismatches, checks_done, n, st;

  byte_load_if lnk ();
  byte_load_device #(.IMAGE_BYTES(NBYTES)) i_byte_load_device (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link(lnk), .use_user_clk_i(use_user_clk_i), .user_startup_clock_i(user_startup_clock_i),
    .byte_ready_i(byte_ready_i), .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o),
    .user_mode_o(user_mode_o), .user_io_o(user_io_o));
  byte_load_host i_byte_load_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(lnk), .start_i(start_i),
    .src_valid_i(src_valid_i), .src_data_i(src_data_i), .src_ready_o(src_ready_o), .busy_o(busy_o),
    .error_o(error_o), .done_o(done_o));
  byte_load_sva i_byte_load_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .config_request_n(lnk.config_request_n),
    .cfg_state_flag_n(lnk.cfg_state_flag_n), .load_complete(lnk.load_complete), .load_clock(lnk.load_clock),
    .load_data(lnk.load_data), .load_data_oe(lnk.load_data_oe));

  always #5 sys_clk_i = ~sys_clk_i;
  // start-up clock, off the system grid in phase
  always #80 if (uclk_run) user_startup_clock_i <= ~user_startup_clock_i;

  // ==========================================================
  // source, sink and byte model
  always @(posedge sys_clk_i) begin
    byte_ready_i <= stall ? 1'b0 : (($random(seed) & 3) != 0);
    // the source holds a byte and its valid until the host takes it, then may go idle at random
    if (src_valid_i === 1'b1 && src_ready_o === 1'b1) begin
      exp_q.push_back(src_data_i);
      src_data_i  <= 8'($random(seed));
      src_valid_i <= (($random(seed) & 3) != 0);
    end else if (src_valid_i !== 1'b1) begin
      src_valid_i <= (($random(seed) & 3) != 0);
    end
    if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1) begin
      got_n++;
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("byte data", exp_b, byte_data_o)
    end
  end

  task automatic wait_for(input int lim, ref logic sig, input logic lvl);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task automatic run_cfg(input logic uclk);
    use_user_clk_i <= uclk;
    got_n = 0;
    st = 0;
    @(posedge sys_clk_i) start_i <= 1'b1;
    @(posedge sys_clk_i) start_i <= 1'b0;
    wait_for(200, lnk.load_complete, 1'b0);
    `CHK("reconfig begins", 1'b1, n <= 100)
    repeat (4) @(posedge sys_clk_i);
    `CHK("user mode left", 1'b0, user_mode_o)
    `CHK("host busy", 1'b1, busy_o)
    n = 0;
    // a stall of two byte times fills the two-entry buffer without loss
    while (lnk.load_complete !== 1'b1 && n < 40000) begin
      @(posedge sys_clk_i);
      n++;
      if (got_n == 4 && st < 30) begin
        stall <= 1'b1;
        st++;
      end else stall <= 1'b0;
    end
    if (uclk) begin
      repeat (64) @(posedge sys_clk_i);
      uclk_run <= 1'b1;
      wait_for(8000, user_mode_o, 1'b1);
      `CHK("user clock start-up", 1'b1, n >= 299 * 16 - 16 && n <= 299 * 16 + 100)
      uclk_run <= 1'b0;
    end else begin
      wait_for(12000, user_mode_o, 1'b1);
      `CHK("oscillator start-up", 1'b1, n >= STARTUP_CYC && n <= 10000)
    end
    `CHK("bytes delivered", NBYTES, got_n)
    `CHK("host done", 1'b1, done_o)
    `CHK("host error", 1'b0, error_o)
    `CHK("host idle", 1'b0, busy_o)
    repeat (4) @(posedge sys_clk_i);
    `CHK("user io", lnk.load_data, user_io_o)
    $display("test configuration with user clock %0d ended", uclk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wait_for(5000, lnk.cfg_state_flag_n, 1'b1);
    `CHK("power-on status hold", 1'b1, n >= POR_CYC)
    `CHK("load-complete at power-up", 1'b0, lnk.load_complete)
    $display("test power-up ended");
    run_cfg(1'b0);
    run_cfg(1'b1);
    close_out();
  end

  initial begin
    #600000;
    mismatches++;
    close_out();
  end
endmodule

// >>> verilog/byte_load_device.sv
`timescale 1ns/1ps
module byte_load_device
  import byte_load_pkg::*;
#(
  parameter int unsigned IMAGE_BYTES = 16
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  byte_load_if.device            link,
  input  wire logic              use_user_clk_i,
  input  wire logic              user_startup_clock_i,
  input  wire logic              byte_ready_i,
  output logic                   byte_valid_o,
  output logic [BYTE_W-1:0]      byte_data_o,
  output logic                   user_mode_o,
  output logic [BYTE_W-1:0]      user_io_o
);

  typedef enum logic [2:0] {S_POR, S_RESET, S_STATUS, S_LOAD, S_INIT, S_USER} dev_state_t;

  // ==========================================================
  // synchronisers: first stage read only by the second
  logic [1:0] req_sync_ff, stat_sync_ff, clk_sync_ff, uclk_sync_ff;
  logic       clk_prev_ff, uclk_prev_ff;
  logic [BYTE_W-1:0] data_s1_ff, data_s2_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_sync_ff  <= 2'h3;
      stat_sync_ff <= 2'h0;
      clk_sync_ff  <= 2'h0;
      uclk_sync_ff <= 2'h0;
      clk_prev_ff  <= 1'b0;
      uclk_prev_ff <= 1'b0;
      data_s1_ff   <= 8'h00;
      data_s2_ff   <= 8'h00;
    end else begin
      req_sync_ff  <= {req_sync_ff[0], link.config_request_n};
      stat_sync_ff <= {stat_sync_ff[0], link.cfg_state_flag_n};
      clk_sync_ff  <= {clk_sync_ff[0], link.load_clock};
      uclk_sync_ff <= {uclk_sync_ff[0], user_startup_clock_i};
      clk_prev_ff  <= clk_sync_ff[1];
      uclk_prev_ff <= uclk_sync_ff[1];
      data_s1_ff   <= link.load_data;
      data_s2_ff   <= data_s1_ff;
    end
  end

  logic req_n, stat_n, clk_rise, uclk_rise;
  assign req_n     = req_sync_ff[1];
  assign stat_n    = stat_sync_ff[1];
  assign clk_rise  = clk_sync_ff[1] & ~clk_prev_ff;
  assign uclk_rise = uclk_sync_ff[1] & ~uclk_prev_ff;

  // ==========================================================
  // sequencer
  dev_state_t       state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] bytes_ff;
  logic             stat_low_ff;
  logic             done_low_ff;
  logic             buf_ready;

  // the data sampled two cycles after the raw pin matches the edge detect
  logic capture;
  assign capture = (state_ff == S_LOAD) && clk_rise && stat_n && req_n;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff    <= S_POR;
      cnt_ff      <= '0;
      bytes_ff    <= '0;
      stat_low_ff <= 1'b1;
      done_low_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      // request low aborts any stage except S_POR; two sync stages keep the response well inside 800 ns
      if (!req_n && state_ff != S_POR) begin
        state_ff    <= S_RESET;
        stat_low_ff <= 1'b1;
        done_low_ff <= 1'b1;
        cnt_ff      <= '0;
        bytes_ff    <= '0;
      end else begin
        case (state_ff)
          S_POR: if (cnt_ff >= cnt_of(POR_CYC - 1)) begin
            state_ff <= S_RESET;
            cnt_ff   <= '0;
          end
          S_RESET: begin
            stat_low_ff <= 1'b1;
            if (cnt_ff >= cnt_of(STATUS_LOW_CYC - 1)) begin
              state_ff <= S_STATUS;
            end
          end
          S_STATUS: begin
            stat_low_ff <= 1'b0;
            // someone else stretching status low keeps us here
            if (stat_n) begin
              state_ff <= S_LOAD;
              bytes_ff <= '0;
            end
          end
          S_LOAD: begin
            if (capture && buf_ready) begin
              bytes_ff <= bytes_ff + 1'b1;
              if (bytes_ff == cnt_of(IMAGE_BYTES - 1)) begin
                state_ff    <= S_INIT;
                done_low_ff <= 1'b0;
                cnt_ff      <= '0;
              end
            end
          end
          S_INIT: begin
            if (use_user_clk_i) begin
              if (uclk_rise) cnt_ff <= cnt_ff + 1'b1;
              else cnt_ff <= cnt_ff;
              if (uclk_rise && cnt_ff >= cnt_of(USER_CLK_PERIODS - 1)) begin
                state_ff <= S_USER;
              end
            end else if (cnt_ff >= cnt_of(STARTUP_CYC - 1)) begin
              state_ff <= S_USER;
            end
          end
          S_USER: cnt_ff <= '0;
          default: state_ff <= S_RESET;
        endcase
      end
    end
  end

  // status drive is also forced by the synchronised request low so the 800 ns bound holds
  assign link.cfg_state_flag_n_dev_oe = stat_low_ff | (state_ff != S_POR && !req_n);
  assign link.load_complete_oe        = done_low_ff | !req_n;
  assign user_mode_o                  = (state_ff == S_USER);

  // ==========================================================
  // two-entry buffer toward the configuration memory
  logic [BYTE_W-1:0] buf_mem_ff [2];
  logic              wr_ptr_ff, rd_ptr_ff;
  logic [1:0]        fill_ff;
  logic              push, pop;
  assign buf_ready    = (fill_ff != 2'h2);
  assign push         = capture && buf_ready;
  assign pop          = byte_valid_o && byte_ready_i;
  assign byte_valid_o = (fill_ff != 2'h0);
  assign byte_data_o  = buf_mem_ff[rd_ptr_ff];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_mem_ff[0] <= 8'h00;
      buf_mem_ff[1] <= 8'h00;
      wr_ptr_ff     <= 1'b0;
      rd_ptr_ff     <= 1'b0;
      fill_ff       <= 2'h0;
    end else begin
      if (push) begin
        buf_mem_ff[wr_ptr_ff] <= data_s2_ff;
        wr_ptr_ff             <= ~wr_ptr_ff;
      end
      if (pop) rd_ptr_ff <= ~rd_ptr_ff;
      fill_ff <= fill_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // ==========================================================
  // after loading the data pins serve as plain user inputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) user_io_o <= 8'h00;
    else if (state_ff == S_USER) user_io_o <= data_s2_ff;
  end

endmodule

// >>> verilog/byte_load_host.sv
`timescale 1ns/1ps
module byte_load_host
  import byte_load_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  byte_load_if.host              link,
  input  wire logic              start_i,
  input  wire logic              src_valid_i,
  input  wire logic [BYTE_W-1:0] src_data_i,
  output logic                   src_ready_o,
  output logic                   busy_o,
  output logic                   error_o,
  output logic                   done_o
);

  typedef enum logic [2:0] {H_IDLE, H_REQ, H_WAIT_STAT, H_WAIT_CLK, H_LOAD, H_DONE} host_state_t;

  // ==========================================================
  // synchronisers for the open-drain lines
  logic [1:0] stat_sync_ff, done_sync_ff;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_sync_ff <= 2'h0;
      done_sync_ff <= 2'h0;
    end else begin
      stat_sync_ff <= {stat_sync_ff[0], link.cfg_state_flag_n};
      done_sync_ff <= {done_sync_ff[0], link.load_complete};
    end
  end

  host_state_t       state_ff;
  logic [CNT_W-1:0]  cnt_ff, since_req_ff;
  logic [3:0]        div_ff;
  logic              req_n_ff, clk_ff, err_ff, have_ff;
  logic              take;
  logic [BYTE_W-1:0] data_ff;

  // a byte is fetched at the clock fall or while parked low, never while one still waits on the pins
  assign src_ready_o = (state_ff == H_LOAD) && stat_sync_ff[1] && !done_sync_ff[1]
                       && div_ff == 4'(LINK_HALF_PERIOD - 1) && !have_ff;
  assign take        = src_ready_o && src_valid_i;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff     <= H_IDLE;
      cnt_ff       <= '0;
      since_req_ff <= '0;
      div_ff       <= '0;
      req_n_ff     <= 1'b1;
      clk_ff       <= 1'b0;
      err_ff       <= 1'b0;
      have_ff      <= 1'b0;
      data_ff      <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      if (since_req_ff != '1) since_req_ff <= since_req_ff + 1'b1;
      case (state_ff)
        H_IDLE: if (start_i) begin
          state_ff <= H_REQ;
          req_n_ff <= 1'b0;
          cnt_ff   <= '0;
          err_ff   <= 1'b0;
        end
        H_REQ: if (cnt_ff >= cnt_of(REQ_LOW_CYC)) begin
          req_n_ff     <= 1'b1;
          since_req_ff <= '0;
          state_ff     <= H_WAIT_STAT;
        end
        H_WAIT_STAT: if (stat_sync_ff[1]) begin
          cnt_ff   <= '0;
          state_ff <= H_WAIT_CLK;
        end
        H_WAIT_CLK: if (cnt_ff >= cnt_of(STAT_CLK_CYC) && since_req_ff >= cnt_of(REQ_CLK_CYC)) begin
          div_ff   <= '0;
          have_ff  <= 1'b0;
          state_ff <= H_LOAD;
        end
        H_LOAD: begin
          if (!stat_sync_ff[1]) begin
            err_ff   <= 1'b1;
            req_n_ff <= 1'b0;
            cnt_ff   <= '0;
            clk_ff   <= 1'b0;
            have_ff  <= 1'b0;
            state_ff <= H_REQ;
          end else if (done_sync_ff[1]) begin
            clk_ff   <= 1'b0;
            state_ff <= H_DONE;
          end else begin
            div_ff <= div_ff + 1'b1;
            if (div_ff == 4'(LINK_HALF_PERIOD - 1)) begin
              div_ff <= '0;
              // the clock rises only over a byte already on the pins; with none it stays parked low
              if (clk_ff) begin
                clk_ff <= 1'b0;
              end else if (have_ff) begin
                clk_ff  <= 1'b1;
                have_ff <= 1'b0;
              end
              if (take) begin
                data_ff <= src_data_i;
                have_ff <= 1'b1;
              end
            end
          end
        end
        H_DONE: if (start_i) begin
          state_ff <= H_REQ;
          req_n_ff <= 1'b0;
          cnt_ff   <= '0;
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  assign link.config_request_n         = req_n_ff;
  assign link.load_clock               = clk_ff;
  assign link.load_data                = data_ff;
  assign link.load_data_oe             = (state_ff == H_LOAD);
  assign link.cfg_state_flag_n_host_oe = 1'b0;
  assign busy_o                        = (state_ff != H_IDLE) && (state_ff != H_DONE);
  assign error_o                       = err_ff;
  assign done_o                        = (state_ff == H_DONE);

endmodule

// >>> verilog/byte_load_if.sv
`timescale 1ns/1ps
interface byte_load_if;
  import byte_load_pkg::*;
  logic              config_request_n;
  logic              cfg_state_flag_n_dev_oe;
  logic              cfg_state_flag_n_host_oe;
  logic              load_complete_oe;
  logic              load_clock;
  logic [BYTE_W-1:0] load_data;
  logic              load_data_oe;
  logic              cfg_state_flag_n;
  logic              load_complete;

  // open-drain lines with pull-ups
  assign cfg_state_flag_n = ~(cfg_state_flag_n_dev_oe | cfg_state_flag_n_host_oe);
  assign load_complete    = ~load_complete_oe;

  modport device (
    input  config_request_n,
    input  load_clock,
    input  load_data,
    input  cfg_state_flag_n,
    input  load_complete,
    output cfg_state_flag_n_dev_oe,
    output load_complete_oe
  );
  modport host (
    output config_request_n,
    output load_clock,
    output load_data,
    output load_data_oe,
    output cfg_state_flag_n_host_oe,
    input  cfg_state_flag_n,
    input  load_complete
  );
endinterface

// >>> verilog/byte_load_pkg.sv
package byte_load_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned SYS_CLK_MHZ       = 100;
  localparam int unsigned POR_DELAY_US      = 12;
  localparam int unsigned REQ_TO_LOW_NS     = 800;
  localparam int unsigned REQ_LOW_MIN_US    = 2;
  localparam int unsigned STATUS_LOW_MIN_US = 10;
  localparam int unsigned REQ_TO_CLK_MIN_US = 100;
  localparam int unsigned STAT_TO_CLK_MIN_US = 2;
  localparam int unsigned DONE_TO_USER_MIN_US = 20;
  localparam int unsigned USER_CLK_WAIT_MAX_CLK = 4;
  localparam int unsigned USER_CLK_PERIODS  = 299;
  localparam int unsigned LINK_HALF_PERIOD  = 8;

  // least times round up; all are whole microseconds here
  localparam int unsigned POR_CYC        = POR_DELAY_US * SYS_CLK_MHZ;
  localparam int unsigned REQ_LOW_CYC    = REQ_LOW_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned STATUS_LOW_CYC = STATUS_LOW_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned REQ_CLK_CYC    = REQ_TO_CLK_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned STAT_CLK_CYC   = STAT_TO_CLK_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned STARTUP_CYC    = DONE_TO_USER_MIN_US * SYS_CLK_MHZ;
  localparam int unsigned REQ_TO_LOW_CYC = (REQ_TO_LOW_NS * SYS_CLK_MHZ) / 1000;

  localparam int unsigned CNT_W   = 16;
  localparam int unsigned BYTE_W  = 8;

  // ==========================================================
  // helper
  function automatic logic [CNT_W-1:0] cnt_of(input int unsigned c);
    cnt_of = CNT_W'(c);
  endfunction

endpackage
